// ### core/stepper_ctrl.sv
// four-channel stepper pulse controller with panel inputs and ahb-lite registers
//
// Design decisions made here: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
// Behaviour
// - four channels pulse concurrently and independently
// - single step move counts 0 to 9999
// - trapezoidal ramp up, run, ramp down
// - hold-off released while moving, restored after
// - limit enable and contact type per channel
// - limit or stop halts, slow or immediate
// - selected channels start in same cycle
// - indicators for limits, home and hold-off
// - display shows count, target or preset
// - local panel or remote command control
// - setup only in local; blocks remote
// - enable toggle local only; scanning stays enabled
// - remote drives channels regardless of enable
// - local preset loads position of enabled channels
// - preset plus stop at power-up restores defaults
// - local start runs enabled channels, mode, speed
// - continuous start arms; jog sets direction
// - start ignored on a pulsing channel
// - stop works in local and remote
// - home seek runs until home sensor active
// - offset moves relative by displayed count
// - target moves to displayed absolute position
// - mode button cycles continuous, target, offset, home
// - jog held 0.5 s or past count continues
// - no pulses while in setup
module stepper_ctrl
  import stepper_pkg::*;
#(
  parameter int JOG_HOLD = stepper_pkg::JOG_HOLD_CYC,
  parameter logic [7:0] RAMP_MAX = 8'h10
) (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // front panel
  input wire logic remote_btn,
  input wire logic setup_btn,
  input wire logic mode_btn,
  input wire logic speed_btn,
  input wire logic [stepper_pkg::NCH-1:0] enable_btn,
  input wire logic preset_btn,
  input wire logic start_btn,
  input wire logic stop_btn,
  input wire logic jog_cw,
  input wire logic jog_ccw,
  // switches
  input wire logic [stepper_pkg::NCH-1:0] cw_ls_in,
  input wire logic [stepper_pkg::NCH-1:0] ccw_ls_in,
  input wire logic [stepper_pkg::NCH-1:0] home_in,
  // motor drivers
  output logic [stepper_pkg::NCH-1:0] cw_pulse,
  output logic [stepper_pkg::NCH-1:0] ccw_pulse,
  output logic [stepper_pkg::NCH-1:0] hold_off,
  // indicators
  output logic [stepper_pkg::NCH-1:0] cw_limit_indicator,
  output logic [stepper_pkg::NCH-1:0] ccw_limit_indicator,
  output logic [stepper_pkg::NCH-1:0] home_indicator,
  output logic [stepper_pkg::NCH-1:0] motor_free_indicator,
  output logic [stepper_pkg::NCH-1:0] start_indicator,
  output logic [stepper_pkg::NCH-1:0] enable_indicator,
  output logic remote_indicator,
  output logic setup_indicator,
  output stepper_pkg::mode_t run_mode,
  output logic [1:0] speed_sel,
  output logic [stepper_pkg::NCH*24-1:0] secondary_display
);
  import stepper_pkg::*;

  function automatic state_t state_rst();
    state_rst = '0;
    state_rst.mode = continuous_mode;
    state_rst.spd_h = SPD_H_DEF;
    state_rst.spd_m = SPD_M_DEF;
    state_rst.spd_l = SPD_L_DEF;
    state_rst.rate = RATE_DEF;
    state_rst.jog_cnt = JOG_DEF;
    for (int k = 0; k < NCH; k++) begin
      state_rst.ch[k].cfg = CFG_DEF;
    end
  endfunction : state_rst

  localparam state_t ST_RST = state_rst();

  function automatic logic [23:0] mag(input logic signed [23:0] v);
    mag = v[23] ? 24'(-v) : 24'(v);
  endfunction : mag

  state_t st_r;
  state_t st_nxt;
  logic [NCH-1:0] cw_on;
  logic [NCH-1:0] ccw_on;
  logic [NCH-1:0] home_on;
  logic [NCH-1:0] go_req;
  logic [NCH-1:0] cmd_start;
  logic [NCH-1:0] cmd_stop;
  logic cmd_wr;
  logic local_ok;

  assign cmd_wr = st_r.a_valid && st_r.a_write && st_r.a_addr == A_CMD && st_r.remote;
  assign cmd_start = cmd_wr ? hwdata[3:0] : 4'h0;
  assign cmd_stop = cmd_wr ? hwdata[7:4] : 4'h0;
  assign local_ok = !st_r.remote;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      assign cw_on[g] = cw_ls_in[g] ^ st_r.ch[g].cfg[LS_NC];
      assign ccw_on[g] = ccw_ls_in[g] ^ st_r.ch[g].cfg[LS_NC];
      assign home_on[g] = home_in[g] ^ st_r.ch[g].cfg[HOME_NC];
      // remote commands ignore the panel enable
      assign go_req[g] = (local_ok && start_btn && st_r.enabled[g])
                         || cmd_start[g];
      assign cw_pulse[g] = st_r.ch[g].cw_p;
      assign ccw_pulse[g] = st_r.ch[g].ccw_p;
      assign hold_off[g] = st_r.ch[g].hold;
      assign cw_limit_indicator[g] = st_r.ch[g].ind[0];
      assign ccw_limit_indicator[g] = st_r.ch[g].ind[1];
      assign home_indicator[g] = st_r.ch[g].ind[2];
      assign motor_free_indicator[g] = st_r.ch[g].ind[3];
      assign start_indicator[g] = st_r.ch[g].armed;
      assign secondary_display[g*24 +: 24] = st_r.ch[g].disp;
    end
  endgenerate

  assign hreadyout = ce;
  assign hresp = 1'b0;
  assign hrdata = st_r.rdata;
  assign enable_indicator = st_r.enabled;
  assign remote_indicator = st_r.remote;
  assign setup_indicator = st_r.setup;
  assign run_mode = st_r.mode;
  assign speed_sel = st_r.speed;

  always_comb begin
    chan_t c;
    logic [15:0] spd;
    logic [23:0] per;
    logic [23:0] rem_after;
    logic lim_hit;
    logic slow;
    logic jog_any;
    logic [3:0] idx;
    c = '0;
    spd = '0;
    per = '0;
    rem_after = '0;
    lim_hit = 1'b0;
    slow = 1'b0;
    jog_any = jog_cw ^ jog_ccw;
    idx = st_r.a_addr[5:2];
    st_nxt = st_r;
    if (ce) begin
      // address phase is captured, read data prepared for the data phase
      st_nxt.a_valid = hsel && htrans[1] && hready;
      st_nxt.a_write = hwrite;
      st_nxt.a_addr = haddr[7:0];
      st_nxt.rdata = '0;
      if (hsel && htrans[1] && hready && !hwrite) begin
        unique case (haddr[7:4])
          4'h0: begin
            unique case (haddr[3:2])
              2'h0: st_nxt.rdata = {24'h0, st_r.enabled, st_r.speed, st_r.mode};
              2'h1: begin
                for (int i = 0; i < NCH; i++) begin
                  st_nxt.rdata[2+i] = st_r.ch[i].busy;
                  st_nxt.rdata[6+i] = st_r.ch[i].armed;
                  st_nxt.rdata[10+i] = st_r.ch[i].hold;
                end
                st_nxt.rdata[1:0] = {st_r.setup, st_r.remote};
              end
              2'h2: st_nxt.rdata = '0;
              2'h3: st_nxt.rdata = {16'h0, st_r.spd_h};
            endcase
          end
          4'h1: begin
            unique case (haddr[3:2])
              2'h0: st_nxt.rdata = {16'h0, st_r.spd_m};
              2'h1: st_nxt.rdata = {16'h0, st_r.spd_l};
              2'h2: st_nxt.rdata = {24'h0, st_r.rate};
              2'h3: st_nxt.rdata = {18'h0, st_r.jog_cnt};
            endcase
          end
          A_CFG_BASE: st_nxt.rdata = {25'h0, st_r.ch[haddr[3:2]].cfg};
          A_MOVE_BASE: st_nxt.rdata = 32'(st_r.ch[haddr[3:2]].move_val);
          A_PRESET_BASE: st_nxt.rdata = 32'(st_r.ch[haddr[3:2]].preset);
          A_POS_BASE: st_nxt.rdata = 32'(st_r.ch[haddr[3:2]].pos);
          default: st_nxt.rdata = '0;
        endcase
      end
      // data phase writes; mode and enables only from remote
      if (st_r.a_valid && st_r.a_write) begin
        unique case (st_r.a_addr[7:4])
          4'h0: begin
            if (st_r.a_addr == A_MODE && st_r.remote) begin
              st_nxt.mode = mode_t'(hwdata[1:0]);
              st_nxt.speed = hwdata[3:2];
              st_nxt.enabled = hwdata[7:4];
            end
            if (st_r.a_addr == A_SPD_H) st_nxt.spd_h = hwdata[15:0];
          end
          4'h1: begin
            if (st_r.a_addr == A_SPD_M) st_nxt.spd_m = hwdata[15:0];
            if (st_r.a_addr == A_SPD_L) st_nxt.spd_l = hwdata[15:0];
            if (st_r.a_addr == A_RATE) st_nxt.rate = hwdata[7:0];
            if (st_r.a_addr == A_JOG) st_nxt.jog_cnt = hwdata[13:0];
          end
          A_CFG_BASE: st_nxt.ch[idx[1:0]].cfg = hwdata[6:0];
          A_MOVE_BASE: st_nxt.ch[idx[1:0]].move_val = hwdata[23:0];
          A_PRESET_BASE: st_nxt.ch[idx[1:0]].preset = hwdata[23:0];
          default: st_nxt.a_write = st_nxt.a_write;
        endcase
      end
      // panel controls
      if (remote_btn) begin
        if (st_r.remote) st_nxt.remote = 1'b0;
        else if (!st_r.setup) st_nxt.remote = 1'b1;
      end
      if (setup_btn && local_ok) st_nxt.setup = !st_r.setup;
      if (local_ok && !st_r.setup) begin
        if (mode_btn) st_nxt.mode = mode_t'(st_r.mode + 2'h1);
        if (speed_btn) st_nxt.speed = (st_r.speed == 2'h2) ? 2'h0 : st_r.speed + 2'h1;
        for (int i = 0; i < NCH; i++) begin
          // a scanning or armed channel keeps its enable
          if (enable_btn[i] && !(st_r.enabled[i] && (st_r.ch[i].armed
              || (st_r.ch[i].busy && st_r.ch[i].cont)))) begin
            st_nxt.enabled[i] = !st_r.enabled[i];
          end
        end
      end
      unique case (st_r.speed)
        2'h0: spd = st_r.spd_h;
        2'h1: spd = st_r.spd_m;
        default: spd = st_r.spd_l;
      endcase
      for (int i = 0; i < NCH; i++) begin
        c = st_nxt.ch[i];
        c.cw_p = 1'b0;
        c.ccw_p = 1'b0;
        lim_hit = c.cfg[LS_EN] && (c.dir ? ccw_on[i] : cw_on[i]);
        per = 24'(spd) + 24'(16'(RAMP_MAX - c.ramp) * 16'(st_r.rate));
        rem_after = c.remaining - 24'h1;
        if (c.busy) begin
          if (lim_hit) begin
            if (c.cfg[LS_FAST]) c.busy = 1'b0;
            else c.decel = 1'b1;
          end
          if (stop_btn || cmd_stop[i]) begin
            c.armed = 1'b0;
            if (c.cfg[PB_FAST]) c.busy = 1'b0;
            else c.decel = 1'b1;
          end
          if (c.kind == home_seek_mode && home_on[i]) c.busy = 1'b0;
          if (c.jog && !(jog_any && (jog_ccw == c.dir))) c.decel = 1'b1;
          if (c.jog && !c.cont) begin
            c.jog_tmr = c.jog_tmr + 27'h1;
            if (c.jog_tmr >= 27'(JOG_HOLD - 1)) c.cont = 1'b1;
          end
          if (c.busy && !st_r.setup) begin
            if (c.tick != 24'h0) begin
              c.tick = c.tick - 24'h1;
            end else if (c.decel && c.ramp == 8'h0) begin
              c.busy = 1'b0;
            end else begin
              c.cw_p = !c.dir;
              c.ccw_p = c.dir;
              c.pos = c.dir ? c.pos - 24'sh1 : c.pos + 24'sh1;
              if (!c.cont) begin
                c.remaining = rem_after;
                if (rem_after == 24'h0) begin
                  if (c.jog) c.cont = 1'b1;
                  else c.busy = 1'b0;
                end
              end
              // trapezoid: climb, hold, descend when remaining meets ramp
              slow = c.decel || (!c.cont && rem_after <= 24'(c.ramp));
              if (slow && c.ramp != 8'h0) c.ramp = c.ramp - 8'h1;
              else if (!slow && c.ramp < RAMP_MAX) c.ramp = c.ramp + 8'h1;
              c.tick = per;
            end
          end
        end else if (!st_r.setup) begin
          if (stop_btn || cmd_stop[i]) c.armed = 1'b0;
          c.tick = 24'h0;
          c.ramp = 8'h0;
          c.decel = 1'b0;
          c.cont = 1'b0;
          c.jog = 1'b0;
          c.jog_tmr = '0;
          // tick is zero so all started channels pulse on the same edge
          if (go_req[i] && !stop_btn && !cmd_stop[i]) begin
            c.kind = st_r.mode;
            unique case (st_r.mode)
              continuous_mode: c.armed = 1'b1;
              offset_move_mode: begin
                c.dir = c.move_val[23];
                c.remaining = (mag(c.move_val) > MAX_STEP) ? MAX_STEP
                              : mag(c.move_val);
                c.busy = c.remaining != 24'h0;
              end
              target_move_mode: begin
                c.dir = c.move_val < c.pos;
                c.remaining = mag(c.move_val - c.pos);
                c.busy = c.remaining != 24'h0;
              end
              home_seek_mode: begin
                c.dir = c.cfg[HOME_CCW];
                c.cont = 1'b1;
                c.busy = !home_on[i];
              end
            endcase
          end else if (local_ok && st_r.enabled[i] && jog_any && !stop_btn) begin
            c.jog = 1'b1;
            c.busy = 1'b1;
            c.dir = jog_ccw;
            c.kind = st_r.mode;
            c.remaining = 24'(st_r.jog_cnt);
            c.cont = c.armed || st_r.jog_cnt == 14'h0;
          end
        end
        if (local_ok && preset_btn && st_r.enabled[i]) c.pos = c.preset;
        c.hold = c.cfg[HOLD_EN] && !c.busy;
        c.ind = {c.hold, home_on[i], ccw_on[i], cw_on[i]};
        c.disp = (st_r.mode == continuous_mode) ? c.preset : c.move_val;
        st_nxt.ch[i] = c;
      end
      // power-up strap: preset and stop held at the first enabled cycle
      if (!st_r.init_done) begin
        st_nxt.init_done = 1'b1;
        if (preset_btn && stop_btn) begin
          st_nxt.spd_h = ST_RST.spd_h;
          st_nxt.spd_m = ST_RST.spd_m;
          st_nxt.spd_l = ST_RST.spd_l;
          st_nxt.rate = ST_RST.rate;
          st_nxt.jog_cnt = ST_RST.jog_cnt;
          st_nxt.mode = ST_RST.mode;
          st_nxt.speed = ST_RST.speed;
          st_nxt.enabled = ST_RST.enabled;
          st_nxt.remote = ST_RST.remote;
          for (int i = 0; i < NCH; i++) begin
            st_nxt.ch[i].cfg = CFG_DEF;
            st_nxt.ch[i].move_val = '0;
            st_nxt.ch[i].preset = '0;
          end
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) st_r <= ST_RST;
    else st_r <= st_nxt;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  chk_setup_no_pulse: assert property (ce && st_r.setup |=> cw_pulse == 4'h0
    && ccw_pulse == 4'h0) else $error("pulse emitted during setup");
  chk_hold_release: assert property (st_r.ch[0].busy |-> !hold_off[0])
    else $error("hold-off asserted while moving");
  chk_pos_count: assert property ($past(ce) && cw_pulse[0] && !$past(preset_btn)
    |-> st_r.ch[0].pos == $past(st_r.ch[0].pos) + 24'sh1) else $error("position not counted");
  chk_start_ignored: assert property (ce && st_r.ch[0].busy && go_req[0]
    |=> st_r.ch[0].dir == $past(st_r.ch[0].dir) && st_r.ch[0].kind == $past(st_r.ch[0].kind))
    else $error("start disturbed a running channel");
  chk_remote_refused: assert property (ce && st_r.setup && remote_btn |=> !st_r.remote)
    else $error("remote entered during setup");
  chk_limit_fast: assert property (ce && st_r.ch[0].busy && !st_r.ch[0].dir
    && cw_on[0] && st_r.ch[0].cfg[LS_EN] && st_r.ch[0].cfg[LS_FAST] |=> !st_r.ch[0].busy)
    else $error("limit did not halt channel");
  chk_home_stop: assert property (ce && st_r.ch[0].busy && st_r.ch[0].kind == home_seek_mode
    && home_on[0] |=> !st_r.ch[0].busy ##1 !cw_pulse[0] && !ccw_pulse[0])
    else $error("home seek ran past home");
  chk_mode_cycle: assert property (ce && !st_r.remote && !st_r.setup && mode_btn
    |=> st_r.mode == mode_t'($past(st_r.mode) + 2'h1)) else $error("mode did not step");
  chk_offset_clamp: assert property (st_r.ch[0].busy && !st_r.ch[0].cont
    && st_r.ch[0].kind == offset_move_mode |-> st_r.ch[0].remaining <= MAX_STEP)
    else $error("offset count above limit");
  chk_scan_enabled: assert property (ce && st_r.ch[0].armed && st_r.enabled[0]
    && enable_btn[0] |=> st_r.enabled[0]) else $error("armed channel was disabled");
  chk_preset_load: assert property (ce && !st_r.remote && preset_btn && st_r.enabled[0]
    |=> st_r.ch[0].pos == $past(st_r.ch[0].preset)) else $error("preset not loaded");
endmodule : stepper_ctrl

// ### core/stepper_pkg.sv
// constants, register map and state types of the four-axis pulse controller
package stepper_pkg;
  localparam int NCH = 4;
  localparam logic [23:0] MAX_STEP = 24'h00270F;
  localparam int JOG_HOLD_MS = 500;
  localparam int CLK_KHZ = 250000;
  localparam int JOG_HOLD_CYC = JOG_HOLD_MS * CLK_KHZ;
  // register byte offsets; per-channel bases are address bits 7:4
  localparam logic [7:0] A_MODE = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_CMD = 8'h08;
  localparam logic [7:0] A_SPD_H = 8'h0C;
  localparam logic [7:0] A_SPD_M = 8'h10;
  localparam logic [7:0] A_SPD_L = 8'h14;
  localparam logic [7:0] A_RATE = 8'h18;
  localparam logic [7:0] A_JOG = 8'h1C;
  localparam logic [3:0] A_CFG_BASE = 4'h2;
  localparam logic [3:0] A_MOVE_BASE = 4'h3;
  localparam logic [3:0] A_PRESET_BASE = 4'h4;
  localparam logic [3:0] A_POS_BASE = 4'h5;
  // per-channel configuration bits
  localparam int LS_EN = 0;
  localparam int LS_NC = 1;
  localparam int LS_FAST = 2;
  localparam int PB_FAST = 3;
  localparam int HOLD_EN = 4;
  localparam int HOME_CCW = 5;
  localparam int HOME_NC = 6;
  // reset values
  localparam logic [6:0] CFG_DEF = 7'h11;
  localparam logic [15:0] SPD_H_DEF = 16'h00FA;
  localparam logic [15:0] SPD_M_DEF = 16'h03E8;
  localparam logic [15:0] SPD_L_DEF = 16'h0FA0;
  localparam logic [7:0] RATE_DEF = 8'h10;
  localparam logic [13:0] JOG_DEF = 14'h000A;

  typedef enum logic [1:0] {continuous_mode, target_move_mode, offset_move_mode,
                            home_seek_mode} mode_t;

  typedef struct packed {
    logic busy;
    logic armed;
    logic dir;
    logic decel;
    logic cont;
    logic jog;
    mode_t kind;
    logic [23:0] remaining;
    logic [7:0] ramp;
    logic [23:0] tick;
    logic [26:0] jog_tmr;
    logic signed [23:0] pos;
    logic [6:0] cfg;
    logic signed [23:0] move_val;
    logic signed [23:0] preset;
    logic cw_p;
    logic ccw_p;
    logic hold;
    logic [3:0] ind;
    logic [23:0] disp;
  } chan_t;

  typedef struct packed {
    chan_t [NCH-1:0] ch;
    logic remote;
    logic setup;
    logic init_done;
    mode_t mode;
    logic [1:0] speed;
    logic [NCH-1:0] enabled;
    logic [15:0] spd_h;
    logic [15:0] spd_m;
    logic [15:0] spd_l;
    logic [7:0] rate;
    logic [13:0] jog_cnt;
    logic a_valid;
    logic a_write;
    logic [7:0] a_addr;
    logic [31:0] rdata;
  } state_t;
endpackage : stepper_pkg

// ### verif/four_axis_stepper_pulse_control_tb.sv
// self-checking bench for the four-axis pulse controller
`timescale 1ns/1ps
module four_axis_stepper_pulse_control_tb;
  import stepper_pkg::*;
  localparam int MODE_B = 0, START_B = 1, SETUP_B = 2, REMOTE_B = 3, PRESET_B = 4, EN_B = 5;
  logic sys_clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0] htrans = 2'b00, speed_sel;
  logic [2:0] hsize = 3'b010;
  logic remote_btn = 1'b0, setup_btn = 1'b0, mode_btn = 1'b0, preset_btn = 1'b0, jog_ccw = 1'b0;
  logic start_btn = 1'b0, stop_btn = 1'b0, remote_indicator, setup_indicator, sync_watch = 1'b0;
  logic [NCH-1:0] enable_btn = '0, cw_ls_in, ccw_ls_in, home_in, cw_pulse, ccw_pulse, hold_off;
  logic [NCH-1:0] cw_limit_indicator, ccw_limit_indicator, home_indicator, motor_free_indicator;
  logic [NCH-1:0] start_indicator, enable_indicator;
  logic [NCH*24-1:0] secondary_display;
  logic [NCH-1:0][23:0] motor_pos;
  mode_t run_mode;
  int bad_count = 0, tests_run = 0, skew = 0, exp_mode = 0;

  always #2 sys_clk = ~sys_clk;
  // lockstep watch for two channels started by one command
  always @(posedge sys_clk) begin
    if (sync_watch && (cw_pulse[1] !== cw_pulse[2])) skew++;
  end

  stepper_ctrl #(.JOG_HOLD(50)) stepper_ctrl_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .remote_btn(remote_btn), .setup_btn(setup_btn),
    .mode_btn(mode_btn), .speed_btn(1'b0), .enable_btn(enable_btn), .preset_btn(preset_btn),
    .start_btn(start_btn), .stop_btn(stop_btn), .jog_cw(1'b0), .jog_ccw(jog_ccw),
    .cw_ls_in(cw_ls_in), .ccw_ls_in(ccw_ls_in), .home_in(home_in), .cw_pulse(cw_pulse),
    .ccw_pulse(ccw_pulse), .hold_off(hold_off), .cw_limit_indicator(cw_limit_indicator),
    .ccw_limit_indicator(ccw_limit_indicator), .home_indicator(home_indicator),
    .motor_free_indicator(motor_free_indicator), .start_indicator(start_indicator),
    .enable_indicator(enable_indicator), .remote_indicator(remote_indicator),
    .setup_indicator(setup_indicator), .run_mode(run_mode), .speed_sel(speed_sel),
    .secondary_display(secondary_display));

  motor_switch_model motor_switch_model_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .cw_pulse(cw_pulse), .ccw_pulse(ccw_pulse),
    .cw_ls_in(cw_ls_in), .ccw_ls_in(ccw_ls_in), .home_in(home_in), .motor_pos(motor_pos));

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // bounded wait for a condition sampled at rising edges
  task automatic wait_ready(input logic idle);
    for (int n = 0; n < 20000; n++) begin
      @(posedge sys_clk);
      if (!idle && hreadyout === 1'b1) return;
      if (idle && hold_off === 4'hF) return;
    end
    bad_count++;
    tally_and_finish();
  endtask : wait_ready

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= w;
    wait_ready(1'b0);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready(1'b0);
    rd = hrdata;
  endtask : bus

  task automatic press(input int k, input logic [3:0] en);
    @(posedge sys_clk);
    case (k)
      MODE_B: mode_btn <= 1'b1;
      START_B: start_btn <= 1'b1;
      SETUP_B: setup_btn <= 1'b1;
      REMOTE_B: remote_btn <= 1'b1;
      PRESET_B: preset_btn <= 1'b1;
      EN_B: enable_btn <= en;
      default: stop_btn <= 1'b1;
    endcase
    @(posedge sys_clk);
    {mode_btn, start_btn, setup_btn, remote_btn, preset_btn, stop_btn} <= 6'h00;
    enable_btn <= 4'h0;
    repeat (3) @(posedge sys_clk);
  endtask : press

  task automatic step_modes(input int n);
    repeat (n) begin
      press(MODE_B, 4'h0);
      exp_mode = (exp_mode + 1) % 4;
      check("run_mode", 32'(exp_mode), 32'(run_mode));
    end
  endtask : step_modes

  task automatic move(input logic [7:0] a, input logic [31:0] cmd);
    repeat (4) @(posedge sys_clk);
    if (a != 8'h00) bus(1'b1, a, cmd);
    if (a == 8'h00) press(START_B, 4'h0);
    wait_ready(1'b1);
  endtask : move

  task automatic chk_pos(input int c, input logic [31:0] reg_val, input logic [31:0] shaft);
    bus(1'b0, {A_POS_BASE, 2'(c), 2'b00}, 32'h0);
    check("position", reg_val, rd);
    check("shaft", shaft, {{8{motor_pos[c][23]}}, motor_pos[c]});
  endtask : chk_pos

  task automatic sc_defaults();
    bus(1'b0, A_STAT, 32'h0);
    check("status", 32'h00003C00, rd);
    check("hold_off", 32'hF, 32'(hold_off));
    bus(1'b0, {A_CFG_BASE, 4'h0}, 32'h0);
    check("cfg", 32'(CFG_DEF), rd);
    bus(1'b0, 8'hFC, 32'h0);
    check("unmapped", 32'h0, rd);
    bus(1'b1, A_MODE, 32'h2);
    @(posedge sys_clk);
    check("run_mode", 32'h0, 32'(run_mode));
    bus(1'b1, A_SPD_H, 32'h4);
    bus(1'b1, A_RATE, 32'h1);
  endtask : sc_defaults

  task automatic sc_home_offset_target();
    step_modes(3);
    press(EN_B, 4'h1);
    check("enable", 32'h1, 32'(enable_indicator));
    move(8'h00, 32'h0);
    chk_pos(0, 32'h6, 32'h6);
    check("home led", 32'h1, 32'(home_indicator[0]));
    step_modes(3);
    bus(1'b1, {A_MOVE_BASE, 4'h0}, 32'hFFFFFFFE);
    press(START_B, 4'h0);
    check("hold_off moving", 32'h0, 32'(hold_off[0]));
    press(START_B, 4'h0);
    wait_ready(1'b1);
    chk_pos(0, 32'h4, 32'h4);
    check("display", 32'hFFFFFE, 32'(secondary_display[23:0]));
    step_modes(3);
    bus(1'b1, {A_MOVE_BASE, 4'h0}, 32'h9);
    move(8'h00, 32'h0);
    chk_pos(0, 32'h9, 32'h9);
    check("hold_off idle", 32'h1, 32'(hold_off[0]));
    bus(1'b1, {A_PRESET_BASE, 4'h0}, 32'h100);
    press(PRESET_B, 4'h0);
    chk_pos(0, 32'h100, 32'h9);
  endtask : sc_home_offset_target

  task automatic sc_setup();
    press(SETUP_B, 4'h0);
    check("setup", 32'h1, 32'(setup_indicator));
    press(REMOTE_B, 4'h0);
    check("remote", 32'h0, 32'(remote_indicator));
    press(START_B, 4'h0);
    repeat (40) @(posedge sys_clk);
    chk_pos(0, 32'h100, 32'h9);
    press(SETUP_B, 4'h0);
    check("setup", 32'h0, 32'(setup_indicator));
  endtask : sc_setup

  // continuous mode: start only arms, the jog lever then drives ccw
  task automatic sc_scan_jog();
    step_modes(3);
    press(START_B, 4'h0);
    check("armed", 32'h1, 32'(start_indicator));
    press(EN_B, 4'h1);
    check("enable", 32'h1, 32'(enable_indicator));
    jog_ccw <= 1'b1;
    repeat (30) @(posedge sys_clk);
    jog_ccw <= 1'b0;
    wait_ready(1'b1);
    check("jog ccw", 32'h1, 32'(motor_pos[0] < 24'd9));
    bus(1'b0, {A_POS_BASE, 4'h0}, 32'h0);
    check("position", 32'h0F7 + 32'(motor_pos[0]), rd);
    press(6, 4'h0);
    check("disarmed", 32'h0, 32'(start_indicator));
  endtask : sc_scan_jog

  task automatic sc_remote();
    press(REMOTE_B, 4'h0);
    check("remote", 32'h1, 32'(remote_indicator));
    bus(1'b1, A_MODE, 32'h2);
    bus(1'b1, {A_MOVE_BASE, 4'h4}, 32'h7);
    bus(1'b1, {A_MOVE_BASE, 4'h8}, 32'h7);
    sync_watch = 1'b1;
    move(A_CMD, 32'h6);
    sync_watch = 1'b0;
    check("skew", 32'h0, 32'(skew));
    chk_pos(1, 32'h7, 32'h7);
    chk_pos(2, 32'h7, 32'h7);
    bus(1'b1, {A_MOVE_BASE, 4'hC}, 32'd1000);
    bus(1'b1, A_CMD, 32'h8);
    press(6, 4'h0);
    wait_ready(1'b1);
    chk_pos(3, 32'(motor_pos[3]), 32'(motor_pos[3]));
    check("halted", 32'h1, 32'(motor_pos[3] < 24'd1000));
    bus(1'b1, {A_CFG_BASE, 4'h0}, 32'h15);
    bus(1'b1, {A_MOVE_BASE, 4'h0}, 32'd100);
    move(A_CMD, 32'h1);
    chk_pos(0, 32'h10B, 32'd20);
    check("cw limit led", 32'h1, 32'(cw_limit_indicator[0]));
  endtask : sc_remote

  initial begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    sc_defaults();
    sc_home_offset_target();
    sc_setup();
    sc_scan_jog();
    sc_remote();
    tally_and_finish();
  end
endmodule : four_axis_stepper_pulse_control_tb

// ### verif/motor_switch_model.sv
// motor and switch model: shaft position from step pulses drives home and limit switches
`timescale 1ns/1ps
module motor_switch_model
  import stepper_pkg::*;
#(
  parameter int HOME_AT = 6,
  parameter int LIMIT_AT = 20
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // step pulses from the controller
  input wire logic [stepper_pkg::NCH-1:0] cw_pulse,
  input wire logic [stepper_pkg::NCH-1:0] ccw_pulse,
  // normally open switches, high when closed
  output logic [stepper_pkg::NCH-1:0] cw_ls_in,
  output logic [stepper_pkg::NCH-1:0] ccw_ls_in,
  output logic [stepper_pkg::NCH-1:0] home_in,
  // shaft position for the bench
  output logic [stepper_pkg::NCH-1:0][23:0] motor_pos
);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      motor_pos <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        motor_pos[i] <= motor_pos[i] + 24'(cw_pulse[i]) - 24'(ccw_pulse[i]);
      end
    end
  end
  // home flag covers everything at and above the home point
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      home_in[i] = $signed(motor_pos[i]) >= HOME_AT;
      cw_ls_in[i] = $signed(motor_pos[i]) >= LIMIT_AT;
      ccw_ls_in[i] = $signed(motor_pos[i]) <= -LIMIT_AT;
    end
  end
endmodule : motor_switch_model
